// file: fdmd_pkg.sv
// Purpose: constants for the fractional dual-modulus feedback divider
// Assumes: 20 MHz system clock, 40-bit serial frequency word
// Notes: word is nine BCD digits then four control bits, first bit in = MSB
package fdmd_pkg;
	localparam int WORD_BITS = 40;
	localparam int FRAC_DIGITS = 5;
	localparam logic [3:0] TC_DIV10 = 4'h9;
	localparam logic [3:0] TC_DIV11 = 4'ha;
	localparam logic [3:0] SWALLOW_WIN = 4'ha;
	localparam logic [6:0] MAIN_RESTART = 7'h02;
	localparam logic [6:0] MAIN_LAST = 7'h01;
	localparam logic [9:0] BAND_HI_RATIO = 10'h226;
	localparam logic [9:0] FILTER_RATIO = 10'h195;
	localparam logic [39:0] RESET_WORD = 40'h5190000000;
	localparam logic [6:0] RST_MAIN = 7'h33;
	localparam logic [3:0] RST_UNITS = 4'h9;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_NS = 300;
	localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] BIAS_LAST = 4'(SAMPLE_CYC - 1);
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_LATCH = 2'b01,
		SEQ_BIAS = 2'b10
	} fdmd_seq_t;
endpackage

// file: fdmd_frac_acc.sv
// Purpose: BCD phase accumulator for the fractional part
// Assumes: step is a one-cycle pulse once per division cycle
// Notes: carry out of the top decade requests one swallow
`timescale 1ns/1ps
module fdmd_frac_acc
	import fdmd_pkg::*;
#(
	parameter int DIGITS = FRAC_DIGITS
)
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Sync reset, low
	input wire logic step, // Accumulate once
	input wire logic [4*DIGITS-1:0] frac, // Fraction digits
	output logic [4*DIGITS-1:0] phase_q, // Accumulated phase
	output logic carry_q // Swallow request pulse
);
	logic [DIGITS:0] cy;
	logic [4*DIGITS-1:0] phase_d;

	// Decimal add with ripple carry per digit
	assign cy[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < DIGITS; i++)
		begin : g_dig
			logic [4:0] s;
			assign s = {1'b0, phase_q[4*i+:4]} + {1'b0, frac[4*i+:4]} + {4'h0, cy[i]};
			assign cy[i+1] = (s > 5'h09);
			assign phase_d[4*i+:4] = cy[i+1] ? 4'(s - 5'h0a) : s[3:0];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase_q <= '0;
			carry_q <= 1'b0;
		end
		else
		begin
			carry_q <= step & cy[DIGITS];
			if (step)
				phase_q <= phase_d;
		end
	end

	a_acc_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		step && cy[DIGITS] |=> carry_q && phase_q == $past(phase_d))
		else $error("accumulator overflow lost");
endmodule

// file: fdmd_divider.sv
// Purpose: divide-by-N.F feedback divider with swallow and sequencer
// Assumes: oscillator and serial pins are asynchronous to clk
// Notes: oscillator pulses are counted after a two-flop synchroniser
`timescale 1ns/1ps
module fdmd_divider
	import fdmd_pkg::*;
(
	input wire logic clk, // 20 MHz clock
	input wire logic rst_n, // Sync reset, low
	input wire logic osc_in, // Oscillator pulses
	input wire logic ser_clk, // Serial bit clock
	input wire logic ser_data, // Serial data
	input wire logic strobe_n, // Word strobe, low
	output logic div_out, // Cycle end pulse
	output logic restart_n, // Cycle restart, low
	output logic units_terminal_pulse, // Units underflow
	output logic prescale_mod11, // Prescaler at 11
	output logic swallow, // Swallow period
	output logic bias, // Down-ramp bias
	output logic sample, // Loop sample
	output logic interpolator_latch_strobe, // Latch pulse
	output logic [19:0] phase_interpolator_control, // Phase digits
	output logic band_select, // Upper band
	output logic loop_filter, // Extra filter
	output logic [3:0] ctrl_bits // Control bits
);
	logic [2:0] osc_sq;
	logic [2:0] sclk_sq;
	logic [1:0] sdat_sq;
	logic [2:0] stb_sq;
	logic osc_edge;
	logic sclk_edge;
	logic stb_fall;
	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] held_q;
	logic [6:0] main_ld;
	logic [9:0] ratio_ld;
	logic [3:0] units_ld;
	logic [3:0] pre_cnt_q;
	logic mod11_q;
	logic [6:0] main_q;
	logic [3:0] units_q;
	logic units_run_q;
	logic [3:0] per_idx_q;
	logic [3:0] per_idx_d;
	logic pending_q;
	logic swallow_q;
	logic restart_n_q;
	logic div_out_q;
	logic term_q;
	logic pre_pulse;
	logic cycle_end;
	logic unit_term;
	logic units_run_d;
	logic swallow_go;
	logic start_q;
	logic carry;
	logic [19:0] phase;
	logic [19:0] frac_q;
	fdmd_seq_t seq_q;
	logic [3:0] seq_cnt_q;
	logic bias_q;
	logic bias_lat_q;
	logic sample_q;
	logic latch_q;
	logic [19:0] pic_q;
	logic band_q;
	logic filt_q;
	logic [3:0] ctrl_q;

	// Pin synchronisers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			osc_sq <= 3'h0;
			sclk_sq <= 3'h0;
			sdat_sq <= 2'h0;
			stb_sq <= 3'h7;
		end
		else
		begin
			osc_sq <= {osc_sq[1:0], osc_in};
			sclk_sq <= {sclk_sq[1:0], ser_clk};
			sdat_sq <= {sdat_sq[0], ser_data};
			stb_sq <= {stb_sq[1:0], strobe_n};
		end
	end

	assign osc_edge = osc_sq[1] & ~osc_sq[2];
	assign sclk_edge = sclk_sq[1] & ~sclk_sq[2];
	assign stb_fall = ~stb_sq[1] & stb_sq[2];

	// shift forty bits, hold on strobe fall
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			shift_q <= '0;
			held_q <= RESET_WORD;
		end
		else
		begin
			if (sclk_edge)
				shift_q <= {shift_q[WORD_BITS-2:0], sdat_sq[1]};
			if (stb_fall)
				held_q <= shift_q;
		end
	end

	// integer digits split from the held word
	assign main_ld = 7'(({3'h0, held_q[39:36]} * 7'h0a) + {3'h0, held_q[35:32]});
	assign units_ld = held_q[31:28];
	assign ratio_ld = 10'(({3'h0, main_ld} * 10'h00a) + {6'h00, units_ld});

	// prescaler period ends at 10 or 11 pulses
	assign pre_pulse = osc_edge && (pre_cnt_q == (mod11_q ? TC_DIV11 : TC_DIV10));
	// last main step closes the cycle
	assign cycle_end = pre_pulse && (main_q == MAIN_LAST);
	assign unit_term = pre_pulse && units_run_q && (units_q == 4'h1);

	// Next units state and period index
	always_comb
	begin
		units_run_d = units_run_q;
		per_idx_d = per_idx_q;
		if (cycle_end)
		begin
			units_run_d = (units_ld != 4'h0);
			per_idx_d = 4'h0;
		end
		else if (pre_pulse)
		begin
			units_run_d = units_run_q && (units_q != 4'h1);
			if (per_idx_q < SWALLOW_WIN)
				per_idx_d = per_idx_q + 4'h1;
		end
	end

	// swallow only in window, not during 11 or underflow
	// Window judged on the period just ended, so a request held at underflow still lands
	assign swallow_go = pre_pulse && pending_q && !units_run_d && !unit_term
		&& (per_idx_q < SWALLOW_WIN);

	// Oscillator pulse count within a prescaler period
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pre_cnt_q <= 4'h0;
		else if (pre_pulse)
			pre_cnt_q <= 4'h0;
		else if (osc_edge)
			pre_cnt_q <= pre_cnt_q + 4'h1;
	end

	// modulus: 11 while units run or for one swallow
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mod11_q <= 1'b1;
			swallow_q <= 1'b0;
		end
		else if (pre_pulse)
		begin
			mod11_q <= units_run_d | swallow_go;
			swallow_q <= swallow_go;
		end
	end

	// counters, preload only at cycle end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			main_q <= RST_MAIN;
			units_q <= RST_UNITS;
			units_run_q <= (RST_UNITS != 4'h0);
			per_idx_q <= 4'h0;
			frac_q <= RESET_WORD[27:8];
		end
		else
		begin
			units_run_q <= units_run_d;
			per_idx_q <= per_idx_d;
			if (cycle_end)
			begin
				main_q <= main_ld;
				units_q <= units_ld;
				frac_q <= held_q[27:8];
			end
			else if (pre_pulse)
			begin
				main_q <= main_q - 7'h01;
				if (units_run_q)
					units_q <= units_q - 4'h1;
			end
		end
	end

	// pending swallow, a new request wins over the take
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pending_q <= 1'b0;
		else
			pending_q <= carry | (pending_q & ~swallow_go);
	end

	// restart goes low for the final main step
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			restart_n_q <= 1'b1;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= pre_pulse && (main_q == MAIN_RESTART);
			if (pre_pulse && (main_q == MAIN_RESTART))
				restart_n_q <= 1'b0;
			else if (cycle_end)
				restart_n_q <= 1'b1;
		end
	end

	// output pulse and units terminal pulse
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			div_out_q <= 1'b0;
			term_q <= 1'b0;
		end
		else
		begin
			div_out_q <= cycle_end;
			term_q <= unit_term;
		end
	end

	fdmd_frac_acc #(
		.DIGITS(FRAC_DIGITS)
	) u_acc (
		.clk(clk),
		.rst_n(rst_n),
		.step(start_q),
		.frac(frac_q),
		.phase_q(phase),
		.carry_q(carry)
	);

	// sequencer started by restart: latch, then bias
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			seq_q <= SEQ_IDLE;
			seq_cnt_q <= 4'h0;
		end
		else
		begin
			case (seq_q)
				SEQ_IDLE:
				begin
					if (start_q)
						seq_q <= SEQ_LATCH;
				end
				SEQ_LATCH:
				begin
					seq_q <= SEQ_BIAS;
					seq_cnt_q <= 4'h0;
				end
				SEQ_BIAS:
				begin
					seq_cnt_q <= seq_cnt_q + 4'h1;
					if (seq_cnt_q == BIAS_LAST)
						seq_q <= SEQ_IDLE;
				end
				default:
					seq_q <= SEQ_IDLE;
			endcase
		end
	end

	// bias, latched copy, then sample flop
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bias_q <= 1'b0;
			bias_lat_q <= 1'b0;
			sample_q <= 1'b0;
			latch_q <= 1'b0;
			pic_q <= '0;
		end
		else
		begin
			bias_q <= (seq_q == SEQ_BIAS);
			bias_lat_q <= bias_q;
			sample_q <= bias_lat_q;
			latch_q <= (seq_q == SEQ_LATCH);
			if (seq_q == SEQ_LATCH)
				pic_q <= phase;
		end
	end

	// band, filter and control bits at preload
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			band_q <= 1'b0;
			filt_q <= 1'b1;
			ctrl_q <= RESET_WORD[3:0];
		end
		else if (cycle_end)
		begin
			band_q <= (ratio_ld >= BAND_HI_RATIO);
			filt_q <= (ratio_ld >= FILTER_RATIO);
			ctrl_q <= held_q[3:0];
		end
	end

	// Outputs straight from flops
	assign div_out = div_out_q;
	assign restart_n = restart_n_q;
	assign units_terminal_pulse = term_q;
	assign prescale_mod11 = mod11_q;
	assign swallow = swallow_q;
	assign bias = bias_q;
	assign sample = sample_q;
	assign interpolator_latch_strobe = latch_q;
	assign phase_interpolator_control = pic_q;
	assign band_select = band_q;
	assign loop_filter = filt_q;
	assign ctrl_bits = ctrl_q;

	a_reset_state: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> mod11_q && !pending_q && main_q == RST_MAIN)
		else $error("reset state wrong");
	a_start_div11: assert property (@(posedge clk) disable iff (!rst_n)
		cycle_end && units_ld != 4'h0 |=> mod11_q && main_q == $past(main_ld))
		else $error("cycle did not start at 11");
	a_units_step: assert property (@(posedge clk) disable iff (!rst_n)
		pre_pulse && !cycle_end && units_run_q |=> units_q == 4'($past(units_q) - 4'h1))
		else $error("units counter missed a step");
	a_term_div10: assert property (@(posedge clk) disable iff (!rst_n)
		unit_term && !cycle_end |=> term_q && !mod11_q && !units_run_q)
		else $error("underflow did not switch to 10");
	a_restart_low: assert property (@(posedge clk) disable iff (!rst_n)
		pre_pulse && main_q == MAIN_RESTART |=> !restart_n_q && start_q)
		else $error("restart not issued at two");
	a_swallow_one: assert property (@(posedge clk) disable iff (!rst_n)
		swallow_go |=> mod11_q && swallow_q && pre_cnt_q == 4'h0)
		else $error("swallow period not 11");
	a_pend_hold: assert property (@(posedge clk) disable iff (!rst_n)
		unit_term && pending_q |=> pending_q && !swallow_q)
		else $error("pending swallow lost at underflow");
	a_sample_follow: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(bias_q) |-> ##2 sample_q)
		else $error("sample did not follow bias");
endmodule

// file: fdmd_partner.sv
// Purpose: oscillator pulse source and control board serial sender
// Assumes: driven on rising clk edges, osc held still in reset
// Notes: idle data line toggles every clock, serial clock rests low
`timescale 1ns/1ps
module fdmd_partner
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Bench reset, low
	output logic osc_in, // Oscillator pulses
	output logic ser_clk, // Serial clock
	output logic ser_data, // Serial data
	output logic strobe_n // Word strobe, low
);
	int osc_ph;
	logic busy;
	initial
	begin
		osc_ph = 0;
		osc_in = 1'b0;
		ser_clk = 1'b0;
		ser_data = 1'b0;
		strobe_n = 1'b1;
		busy = 1'b0;
	end
	// Oscillator, three clocks high then three low
	always @(posedge clk)
	begin
		osc_ph <= (!rst_n || osc_ph == 5) ? 0 : osc_ph + 1;
		osc_in <= rst_n && (osc_ph < 3);
	end
	// Released data line carries no stale value
	always @(posedge clk)
		if (!busy)
			ser_data <= ~ser_data;
	// Shift one word, first bit MSB, then strobe it in
	task send_word(input logic [39:0] w);
		int i;
		@(posedge clk);
		busy <= 1'b1;
		for (i = 39; i >= 0; i--)
		begin
			@(posedge clk);
			ser_data <= w[i];
			repeat (3) @(posedge clk);
			ser_clk <= 1'b1;
			repeat (4) @(posedge clk);
			ser_clk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		strobe_n <= 1'b0;
		repeat (4) @(posedge clk);
		strobe_n <= 1'b1;
		busy <= 1'b0;
	endtask
endmodule

// file: test_fractional_dual_modulus_divider.sv
// Purpose: self-checking bench for the fractional divider
// Assumes: oscillator period of six clocks, words sent mid-cycle
// Notes: pulse counts are measured between cycle-end pulses
`timescale 1ns/1ps
module test_fractional_dual_modulus_divider
	import fdmd_pkg::*;
;
	logic clk, rst_n, osc_in, ser_clk, ser_data, strobe_n, div_out, restart_n;
	logic units_terminal_pulse, prescale_mod11, swallow, bias, sample;
	logic interpolator_latch_strobe, band_select, loop_filter, osc_q, sw_seen;
	logic [19:0] phase_interpolator_control;
	logic [3:0] ctrl_bits, p_ctl;
	logic [1:0] bias_h;
	logic [39:0] w [4] = '{40'h404000000a, 40'h7040000005, 40'h5500000003, 40'h5190000006};
	int ratio [4] = '{404, 704, 550, 519};
	int term [4] = '{44, 44, 0, 99};
	logic bnd [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	logic flt [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
	int n_errors = 0, n_tests = 0, cnt = 0, cyc_len = 0, term_len = 0, b_cnt = 0;
	int bias_len = 0, l_cnt = 0, latch_len = 0, smis = 0, p_ratio, a, i;
	int r_cnt = 0, restart_len = 0, m_cnt = 0, mod_len = 0;
	localparam int OSC_CYC = 6;
	fdmd_partner u_part (.clk(clk), .rst_n(rst_n), .osc_in(osc_in), .ser_clk(ser_clk),
		.ser_data(ser_data), .strobe_n(strobe_n));
	fdmd_divider dut (.clk(clk), .rst_n(rst_n), .osc_in(osc_in), .ser_clk(ser_clk),
		.ser_data(ser_data), .strobe_n(strobe_n), .div_out(div_out), .restart_n(restart_n),
		.units_terminal_pulse(units_terminal_pulse), .prescale_mod11(prescale_mod11),
		.swallow(swallow), .bias(bias), .sample(sample),
		.interpolator_latch_strobe(interpolator_latch_strobe),
		.phase_interpolator_control(phase_interpolator_control),
		.band_select(band_select), .loop_filter(loop_filter), .ctrl_bits(ctrl_bits));
	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Measure pulses, bias width and sample delay per cycle
	always @(posedge clk)
	begin
		osc_q <= osc_in;
		bias_h <= {bias_h[0], bias};
		if (rst_n && sample !== bias_h[1])
			smis <= smis + 1;
		if (swallow === 1'b1)
			sw_seen <= 1'b1;
		if (units_terminal_pulse === 1'b1)
			term_len <= cnt;
		if (!rst_n || div_out === 1'b1)
		begin
			cyc_len <= cnt;
			cnt <= 0;
			bias_len <= b_cnt;
			b_cnt <= 0;
			latch_len <= l_cnt;
			l_cnt <= 0;
			restart_len <= r_cnt;
			r_cnt <= 0;
			mod_len <= m_cnt;
			m_cnt <= int'(prescale_mod11 === 1'b1);
		end
		else
		begin
			cnt <= cnt + int'(osc_in && !osc_q);
			r_cnt <= r_cnt + int'(restart_n === 1'b0);
			m_cnt <= m_cnt + int'(prescale_mod11 === 1'b1);
			b_cnt <= b_cnt + int'(bias === 1'b1);
			l_cnt <= l_cnt + int'(interpolator_latch_strobe === 1'b1);
		end
	end
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: level %h, wanted %h", $time, got, exp);
		end
	endtask
	task chk_cnt(input int got, input int exp);
		n_tests++;
		if (got != exp)
		begin
			n_errors++;
			$display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
		end
	endtask
	// Wait for one cycle-end pulse, bounded
	task wait_div;
		int k;
		k = 0;
		@(negedge clk);
		while (div_out !== 1'b1 && k < 8000)
		begin
			@(negedge clk);
			k++;
		end
		if (k >= 8000)
		begin
			n_errors++;
			$display("unexpected at %0t: no cycle end", $time);
		end
		// Let the monitor latch the counts of the cycle just ended
		@(negedge clk);
	endtask
	task stop_test;
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (90000) @(posedge clk);
		n_errors++;
		$display("unexpected at %0t: watchdog", $time);
		stop_test();
	end
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		osc_q = 1'b0;
		sw_seen = 1'b0;
		bias_h = 2'b00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk_val(prescale_mod11, 1);
		chk_val({restart_n, div_out, swallow, band_select, loop_filter}, 5'h11);
		chk_val(ctrl_bits, 0);
		p_ratio = 519;
		p_ctl = 4'h0;
		for (i = 0; i < 4; i++)
		begin
			wait_div();
			u_part.send_word(w[i]);
			chk_val(ctrl_bits, p_ctl);
			wait_div();
			chk_cnt(cyc_len, p_ratio);
			wait_div();
			chk_cnt(cyc_len, ratio[i]);
			if (term[i] > 0)
				chk_cnt(term_len, term[i]);
			chk_val(band_select, bnd[i]);
			chk_val(loop_filter, flt[i]);
			chk_val(ctrl_bits, w[i][3:0]);
			chk_cnt(bias_len, SAMPLE_CYC);
			chk_cnt(latch_len, 1);
			chk_cnt(restart_len, 10 * OSC_CYC);
			chk_cnt(mod_len, term[i] * OSC_CYC);
			p_ratio = ratio[i];
			p_ctl = w[i][3:0];
		end
		u_part.send_word(40'h5195000006);
		wait_div();
		wait_div();
		sw_seen = 1'b0;
		wait_div();
		a = cyc_len;
		wait_div();
		chk_cnt(a + cyc_len, 1039);
		chk_val(sw_seen, 1);
		chk_cnt(mod_len, (99 + 11) * OSC_CYC);
		chk_val(phase_interpolator_control, 20'h50000);
		chk_cnt(smis, 0);
		stop_test();
	end
endmodule
